// ---- core/mfsb_pkg.sv ----
// package: offsets, reset word and field positions of the motor fault status bank
package mfsb_pkg;

  // register offsets (device byte address space)
  localparam logic [11:0] MFSB_OFS_DRV   = 12'h0e0;
  localparam logic [11:0] MFSB_OFS_CTRL  = 12'h0e2;
  localparam logic [11:0] MFSB_OFS_ALGO  = 12'h0e4;
  localparam logic [11:0] MFSB_OFS_MTR   = 12'h0e6;
  localparam logic [11:0] MFSB_OFS_MEAS  = 12'h0e8;
  localparam logic [11:0] MFSB_OFS_NVM   = 12'h24c;

  localparam logic [31:0] MFSB_RST_WORD  = 32'h0000_0000;

  // driver stage fault flags
  localparam int MFSB_DRV_SUMMARY   = 31;
  localparam int MFSB_DRV_STEP_DOWN_REGULATOR_OVERCURRENT  = 13;
  localparam int MFSB_DRV_STEP_DOWN_REGULATOR_UNDERVOLTAGE   = 12;
  localparam int MFSB_DRV_CP_UV     = 11;

  // controller fault flags
  localparam int MFSB_CF_SUMMARY    = 31;
  localparam int MFSB_CF_IPD_FREQ   = 29;
  localparam int MFSB_CF_IPD_T1     = 28;
  localparam int MFSB_CF_IPD_T2     = 27;
  localparam int MFSB_CF_MEAS_RL    = 25;
  localparam int MFSB_CF_MEAS_BEMF  = 24;
  localparam int MFSB_CF_ABNORMAL_SPEED_LOCK  = 23;
  localparam int MFSB_CF_ABNORMAL_BACKEMF_LOCK   = 22;
  localparam int MFSB_CF_PHASE_LOSS = 21;
  localparam int MFSB_CF_ANY_LOCK   = 20;
  localparam int MFSB_CF_LOCK_ILIM  = 19;
  localparam int MFSB_CF_HW_ILIM    = 18;
  localparam int MFSB_CF_SUPPLY_UV  = 17;
  localparam int MFSB_CF_SUPPLY_OV  = 16;
  localparam int MFSB_CF_SAT_LO     = 12;
  localparam int MFSB_CF_NVM_WLOCK  = 11;
  localparam int MFSB_CF_NVM_RLOCK  = 10;
  localparam int MFSB_CF_LINK_CRC   = 6;
  localparam int MFSB_CF_NVM_ERR    = 5;
  localparam int MFSB_CF_WDOG       = 3;

  // nonvolatile memory fault flags (16 bit)
  localparam int MFSB_NVM_CRC       = 4;
  localparam int MFSB_NVM_PARITY    = 2;

  // algorithm status
  localparam int MFSB_AS_MOD_LO     = 16;
  localparam int MFSB_AS_DUTY_LO    = 4;
  localparam int MFSB_AS_READY      = 2;

  // motor parameters
  localparam int MFSB_MP_RES_LO     = 24;
  localparam int MFSB_MP_BEMF_LO    = 16;
  localparam int MFSB_MP_IND_LO     = 8;

  // measurement completion status
  localparam int MFSB_MS_RES_DONE   = 31;
  localparam int MFSB_MS_IND_DONE   = 30;
  localparam int MFSB_MS_BEMF_DONE  = 29;
  localparam int MFSB_MS_GAIN_DONE  = 28;
  localparam int MFSB_MS_FREQ_LO    = 24;

endpackage

// ---- core/mfsb_status_bank.sv ----
// read-only fault and status register bank of the motor controller
// Operation
// RULE_01 - bit 13 driver flags: step-down regulator overcurrent while present.
// RULE_02 - bit 12 regulator undervoltage, bit 11 charge pump undervoltage.
// RULE_03 - controller bit 31 is OR of all controller fault bits.
// RULE_04 - bits 29, 28, 27: position detect frequency, timing1, timing2 faults.
// RULE_05 - bit 25 resistance/inductance measure fault, bit 24 back-EMF fault.
// RULE_06 - bits 23, 22, 21 lock causes; bit 20 set on any of them.
// RULE_07 - bit 19 lock current limit, bit 18 hardware lock current limit.
// RULE_08 - bit 17 supply undervoltage, bit 16 supply overvoltage.
// RULE_09 - bits 15..12 speed, current, max speed, bus power saturation.
// RULE_10 - bit 11 memory write lock active, bit 10 read lock active.
// RULE_11 - bit 6 link packet CRC failure, bit 5 memory error.
// RULE_12 - bit 3 watchdog expired without service.
// RULE_13 - memory fault register: bit 4 CRC error, bit 2 parity error.
// RULE_14 - algorithm status 31..16 unsigned 16-bit modulation index.
// RULE_15 - algorithm status 15..4 twelve-bit input duty command.
// RULE_16 - bit 2 zero while copying defaults, one once control allowed.
// RULE_17 - motor params: resistance 31..24, back-EMF 23..16, inductance 15..8.
// RULE_18 - completion flags 31..28, zero until each measurement completes.
// RULE_19 - bits 27..24 recommended switching frequency code.
// RULE_20 - host leaves unlisted offsets alone; they are not modified.
// RULE_21 - driver bit 31 is OR of all driver fault bits.
// RULE_22 - reads have no side effect; reserved bits zero; writes ignored.
`timescale 1ns/1ps

module mfsb_status_bank
  import mfsb_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int MOD_W  = 16,
  parameter int DUTY_W = 12,
  parameter int PAR_W  = 8,
  parameter int FREQ_W = 4
)
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // register read port from serial link decoder
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic              wr_en,
  output logic [31:0]            rd_data,
  output logic                   rd_valid,
  // driver stage fault sources
  input  wire logic              step_down_regulator_overcurrent,
  input  wire logic              step_down_regulator_undervoltage,
  input  wire logic              charge_pump_undervoltage,
  // controller fault sources
  input  wire logic              position_detect_frequency_fault,
  input  wire logic              position_detect_timing1_fault,
  input  wire logic              position_detect_timing2_fault,
  input  wire logic              measure_rl_fault,
  input  wire logic              measure_backemf_fault,
  input  wire logic              abnormal_speed_lock,
  input  wire logic              abnormal_backemf_lock,
  input  wire logic              phase_loss_fault,
  input  wire logic              lock_current_limit_fault,
  input  wire logic              hardware_lock_current_limit_fault,
  input  wire logic              supply_undervoltage_fault,
  input  wire logic              supply_overvoltage_fault,
  input  wire logic [3:0]        loop_saturation,
  input  wire logic              nvm_write_lock,
  input  wire logic              nvm_read_lock,
  input  wire logic              link_crc_fault,
  input  wire logic              nvm_error,
  input  wire logic              watchdog_expired,
  // memory fault sources
  input  wire logic              nvm_crc_error,
  input  wire logic              nvm_parity_error,
  // algorithm status sources
  input  wire logic [MOD_W-1:0]  modulation_index,
  input  wire logic [DUTY_W-1:0] duty_command,
  input  wire logic              system_ready_flag,
  // measurement results
  input  wire logic [PAR_W-1:0]  measured_resistance,
  input  wire logic [PAR_W-1:0]  measured_backemf_constant,
  input  wire logic [PAR_W-1:0]  measured_inductance,
  input  wire logic              resistance_measure_done,
  input  wire logic              inductance_measure_done,
  input  wire logic              backemf_measure_done,
  input  wire logic              gain_calc_done,
  input  wire logic [FREQ_W-1:0] recommended_switch_freq,
  // summary outputs
  output logic                   driver_fault_any,
  output logic                   controller_fault_any
);

  // =========================================================
  // reset release
  logic rst_s1_d;
  logic rst_s1_q;
  logic rst_s2_d;
  logic rst_s2_q;

  always_comb
  begin
    rst_s1_d = 1'b1;
    rst_s2_d = rst_s1_q;
  end

  // only the second stage is read by the rest of the bank
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= rst_s1_d;
      rst_s2_q <= rst_s2_d;
    end
  end

  wire logic rst_n_int = rst_s2_q;

  // =========================================================
  // status word assembly
  logic [31:0] drv_d,  drv_q;
  logic [31:0] ctl_d,  ctl_q;
  logic [31:0] alg_d,  alg_q;
  logic [31:0] mtr_d,  mtr_q;
  logic [31:0] mes_d,  mes_q;
  logic [15:0] nvm_d,  nvm_q;
  logic        any_lock;

  always_comb
  begin
    drv_d = MFSB_RST_WORD;
    drv_d[MFSB_DRV_STEP_DOWN_REGULATOR_OVERCURRENT] = step_down_regulator_overcurrent; // see RULE_01
    drv_d[MFSB_DRV_STEP_DOWN_REGULATOR_UNDERVOLTAGE]  = step_down_regulator_undervoltage; // see RULE_02
    drv_d[MFSB_DRV_CP_UV]    = charge_pump_undervoltage; // see RULE_02
    drv_d[MFSB_DRV_SUMMARY]  = |drv_d; // see RULE_21
  end

  always_comb
  begin
    any_lock = abnormal_speed_lock | abnormal_backemf_lock
             | phase_loss_fault; // see RULE_06
    ctl_d = MFSB_RST_WORD;
    ctl_d[MFSB_CF_IPD_FREQ]   = position_detect_frequency_fault; // see RULE_04
    ctl_d[MFSB_CF_IPD_T1]     = position_detect_timing1_fault; // see RULE_04
    ctl_d[MFSB_CF_IPD_T2]     = position_detect_timing2_fault; // see RULE_04
    ctl_d[MFSB_CF_MEAS_RL]    = measure_rl_fault; // see RULE_05
    ctl_d[MFSB_CF_MEAS_BEMF]  = measure_backemf_fault; // see RULE_05
    ctl_d[MFSB_CF_ABNORMAL_SPEED_LOCK]  = abnormal_speed_lock; // see RULE_06
    ctl_d[MFSB_CF_ABNORMAL_BACKEMF_LOCK]   = abnormal_backemf_lock; // see RULE_06
    ctl_d[MFSB_CF_PHASE_LOSS] = phase_loss_fault; // see RULE_06
    ctl_d[MFSB_CF_ANY_LOCK]   = any_lock; // see RULE_06
    ctl_d[MFSB_CF_LOCK_ILIM]  = lock_current_limit_fault; // see RULE_07
    ctl_d[MFSB_CF_HW_ILIM]    = hardware_lock_current_limit_fault; // see RULE_07
    ctl_d[MFSB_CF_SUPPLY_UV]  = supply_undervoltage_fault; // see RULE_08
    ctl_d[MFSB_CF_SUPPLY_OV]  = supply_overvoltage_fault; // see RULE_08
    ctl_d[MFSB_CF_SAT_LO +: $bits(loop_saturation)] = loop_saturation; // see RULE_09
    ctl_d[MFSB_CF_NVM_WLOCK]  = nvm_write_lock; // see RULE_10
    ctl_d[MFSB_CF_NVM_RLOCK]  = nvm_read_lock; // see RULE_10
    ctl_d[MFSB_CF_LINK_CRC]   = link_crc_fault; // see RULE_11
    ctl_d[MFSB_CF_NVM_ERR]    = nvm_error; // see RULE_11
    ctl_d[MFSB_CF_WDOG]       = watchdog_expired; // see RULE_12
    ctl_d[MFSB_CF_SUMMARY]    = |ctl_d; // see RULE_03
  end

  always_comb
  begin
    nvm_d = 16'h0000;
    nvm_d[MFSB_NVM_CRC]    = nvm_crc_error; // see RULE_13
    nvm_d[MFSB_NVM_PARITY] = nvm_parity_error; // see RULE_13
  end

  always_comb
  begin
    alg_d = MFSB_RST_WORD;
    alg_d[MFSB_AS_MOD_LO +: MOD_W]   = modulation_index; // see RULE_14
    alg_d[MFSB_AS_DUTY_LO +: DUTY_W] = duty_command; // see RULE_15
    alg_d[MFSB_AS_READY]             = system_ready_flag; // see RULE_16
  end

  always_comb
  begin
    mtr_d = MFSB_RST_WORD;
    mtr_d[MFSB_MP_RES_LO +: PAR_W]  = measured_resistance; // see RULE_17
    mtr_d[MFSB_MP_BEMF_LO +: PAR_W] = measured_backemf_constant; // see RULE_17
    mtr_d[MFSB_MP_IND_LO +: PAR_W]  = measured_inductance; // see RULE_17
  end

  always_comb
  begin
    mes_d = MFSB_RST_WORD;
    mes_d[MFSB_MS_RES_DONE]  = resistance_measure_done; // see RULE_18
    mes_d[MFSB_MS_IND_DONE]  = inductance_measure_done; // see RULE_18
    mes_d[MFSB_MS_BEMF_DONE] = backemf_measure_done; // see RULE_18
    mes_d[MFSB_MS_GAIN_DONE] = gain_calc_done; // see RULE_18
    mes_d[MFSB_MS_FREQ_LO +: FREQ_W] = recommended_switch_freq; // see RULE_19
  end

  // live levels, one register per status word
  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      drv_q <= MFSB_RST_WORD;
    end
    else
    begin
      drv_q <= drv_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      ctl_q <= MFSB_RST_WORD;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      alg_q <= MFSB_RST_WORD;
    end
    else
    begin
      alg_q <= alg_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      mtr_q <= MFSB_RST_WORD;
    end
    else
    begin
      mtr_q <= mtr_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      mes_q <= MFSB_RST_WORD;
    end
    else
    begin
      mes_q <= mes_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      nvm_q <= 16'h0000;
    end
    else
    begin
      nvm_q <= nvm_d;
    end
  end

  // =========================================================
  // read port
  logic [31:0] rd_data_d, rd_data_q;
  logic        rd_valid_d, rd_valid_q;

  always_comb
  begin
    // writes never reach the status words; unlisted offsets read zero
    rd_valid_d = rd_en & ~wr_en; // see RULE_22
    rd_data_d  = MFSB_RST_WORD;
    if (rd_en && !wr_en)
    begin
      case (rd_addr)
        MFSB_OFS_DRV:  rd_data_d = drv_q;
        MFSB_OFS_CTRL: rd_data_d = ctl_q;
        MFSB_OFS_ALGO: rd_data_d = alg_q;
        MFSB_OFS_MTR:  rd_data_d = mtr_q;
        MFSB_OFS_MEAS: rd_data_d = mes_q;
        MFSB_OFS_NVM:  rd_data_d = {16'h0000, nvm_q}; // see RULE_22
        default:       rd_data_d = MFSB_RST_WORD; // see RULE_20
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      rd_data_q  <= MFSB_RST_WORD;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data              = rd_data_q;
  assign rd_valid             = rd_valid_q;
  assign driver_fault_any     = drv_q[MFSB_DRV_SUMMARY];
  assign controller_fault_any = ctl_q[MFSB_CF_SUMMARY];

endmodule

// ---- verification/mfsb_host_model.sv ----
// host model: one-cycle register reads and refused write attempts
`timescale 1ns/1ps
module mfsb_host_model
(
  // clock
  input  wire logic        clk_sys,
  // requests from the bench
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  // register port
  output logic             rd_en,
  output logic             wr_en,
  output logic [11:0]      rd_addr
);
  initial {rd_en, wr_en, rd_addr} = '0;
  // released address shows inverse of last value
  always @(posedge clk_sys)
  begin
    // a write attempt raises both strobes; the bank must refuse it
    rd_en   <= #1 go;
    wr_en   <= #1 go & wr;
    rd_addr <= #1 go ? addr : ~rd_addr;
  end
endmodule

// ---- verification/mfsb_status_bank_monitor.sv ----
// checker: read port timing and word layout of the status bank
`timescale 1ns/1ps
module mfsb_status_bank_monitor
  import mfsb_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // register read port
  input wire logic        rd_en,
  input wire logic        wr_en,
  input wire logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  // sources and summaries
  input wire logic        step_down_regulator_overcurrent,
  input wire logic        step_down_regulator_undervoltage,
  input wire logic        charge_pump_undervoltage,
  input wire logic        nvm_crc_error,
  input wire logic        nvm_parity_error,
  input wire logic        driver_fault_any,
  input wire logic        controller_fault_any
);
  logic [1:0] age_q;
  logic [1:0] age_d;
  wire logic [2:0] drv_src = {step_down_regulator_overcurrent,
    step_down_regulator_undervoltage, charge_pump_undervoltage};

  // edges since reset release, saturating
  always_comb age_d = (age_q == 2'd3) ? age_q : age_q + 2'd1;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) age_q <= 2'd0;
    else age_q <= age_d;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    rd_en && !wr_en;
  endsequence
  sequence s_ans(logic [11:0] a);
    rd_valid && $past(rd_addr) == a;
  endsequence

  a_answer_next: assert property (s_take |=> rd_valid)
    else $error("read not answered next cycle");
  a_no_stray: assert property (
    rd_valid |-> $past(rd_en && !wr_en))
    else $error("answer without accepted read");
  a_idle_zero: assert property (!rd_valid |-> rd_data == '0)
    else $error("read data not zero when idle");
  a_reset_quiet: assert property (age_q < 2'd2 |-> !rd_valid
    && rd_data == '0 && !driver_fault_any && !controller_fault_any)
    else $error("outputs active during reset");
  a_drv_word: assert property (s_ans(MFSB_OFS_DRV) |->
    (rd_data & ~32'h8000_3800) == '0 && rd_data[31] == |rd_data[13:11])
    else $error("driver word layout wrong");
  a_ctrl_or: assert property (s_ans(MFSB_OFS_CTRL) |->
    rd_data[31] == |rd_data[30:0] && (rd_data & 32'h4400_0397) == '0)
    else $error("controller summary wrong");
  a_lock_any: assert property (s_ans(MFSB_OFS_CTRL) |->
    rd_data[20] == |rd_data[23:21])
    else $error("any-lock bit wrong");
  a_nvm_word: assert property (
    age_q == 2'd3 ##0 s_ans(MFSB_OFS_NVM) |->
    rd_data == {27'h0, $past(nvm_crc_error, 2), 1'b0,
                $past(nvm_parity_error, 2), 2'b00})
    else $error("memory fault word wrong");
  a_drv_any: assert property (age_q == 2'd3 &&
    drv_src == $past(drv_src) && drv_src == $past(drv_src, 2)
    |-> driver_fault_any == |drv_src)
    else $error("driver summary output wrong");
endmodule

bind mfsb_status_bank mfsb_status_bank_monitor mon (.*);

// ---- verification/tb_mfsb_status_bank.sv ----
// testbench: bit walk, all ones, refused write, back-to-back, mid-run reset
`timescale 1ns/1ps
module tb_mfsb_status_bank
  import mfsb_pkg::*;
;
  localparam logic [11:0] OFS [6] = '{MFSB_OFS_DRV, MFSB_OFS_CTRL,
    MFSB_OFS_ALGO, MFSB_OFS_MTR, MFSB_OFS_MEAS, MFSB_OFS_NVM};
  logic clk_sys = 0, rst_b = 0, go = 0, wr = 0;
  logic [11:0] addr = '0, rd_addr;
  logic rd_en, wr_en, rd_valid, driver_fault_any, controller_fault_any;
  logic [31:0] rd_data;
  logic [31:0] w [6] = '{default: '0};
  int mismatches = 0, check_count = 0;

  mfsb_status_bank dut (.*,
    .step_down_regulator_overcurrent(w[0][13]),
    .step_down_regulator_undervoltage(w[0][12]),
    .charge_pump_undervoltage(w[0][11]),
    .position_detect_frequency_fault(w[1][29]),
    .position_detect_timing1_fault(w[1][28]),
    .position_detect_timing2_fault(w[1][27]),
    .measure_rl_fault(w[1][25]), .measure_backemf_fault(w[1][24]),
    .abnormal_speed_lock(w[1][23]), .abnormal_backemf_lock(w[1][22]),
    .phase_loss_fault(w[1][21]), .lock_current_limit_fault(w[1][19]),
    .hardware_lock_current_limit_fault(w[1][18]),
    .supply_undervoltage_fault(w[1][17]),
    .supply_overvoltage_fault(w[1][16]), .loop_saturation(w[1][15:12]),
    .nvm_write_lock(w[1][11]), .nvm_read_lock(w[1][10]),
    .link_crc_fault(w[1][6]), .nvm_error(w[1][5]),
    .watchdog_expired(w[1][3]), .modulation_index(w[2][31:16]),
    .duty_command(w[2][15:4]), .system_ready_flag(w[2][2]),
    .measured_resistance(w[3][31:24]),
    .measured_backemf_constant(w[3][23:16]),
    .measured_inductance(w[3][15:8]), .resistance_measure_done(w[4][31]),
    .inductance_measure_done(w[4][30]), .backemf_measure_done(w[4][29]),
    .gain_calc_done(w[4][28]), .recommended_switch_freq(w[4][27:24]),
    .nvm_crc_error(w[5][4]), .nvm_parity_error(w[5][2]));
  mfsb_host_model host (.clk_sys, .go, .wr, .addr, .rd_en, .wr_en, .rd_addr);

  initial forever #4 clk_sys = ~clk_sys;

  function automatic logic [31:0] expw(input int i, input logic [31:0] v);
    logic [31:0] m;
    case (i)
      0: m = v & 32'h0000_3800;
      1: m = v & 32'h3bef_fc68;
      2: m = v & 32'hffff_fff4;
      3: m = v & 32'hffff_ff00;
      4: m = v & 32'hff00_0000;
      default: m = v & 32'h0000_0014;
    endcase
    if (i == 1) m[20] = |m[23:21];
    if (i < 2) m[31] = |m;
    return m;
  endfunction

  task automatic give_verdict;
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    addr = a;
    go = 1;
    @(posedge clk_sys) #1 go = 0;
    n = 0;
    do begin @(posedge clk_sys); #1 n++; end
    while (rd_valid !== 1'b1 && n < 4);
    if (rd_valid !== 1'b1)
    begin
      chk("rd_valid", {31'h0, rd_valid}, 32'h1);
      give_verdict();
    end
    else
      d = rd_data;
  endtask

  // reset values, then one source bit at a time in every register
  task automatic t_walk;
    logic [31:0] d;
    for (int i = 0; i < 6; i++)
      for (int b = -1; b < 32; b++)
      begin
        w[i] = (b < 0) ? 32'h0 : 32'h1 << b;
        rd(OFS[i], d);
        chk("status word", d, expw(i, w[i]));
        chk("summaries", {driver_fault_any, controller_fault_any},
            {|(w[0] & 32'h3800), |(w[1] & 32'h3bef_fc68)});
      end
  endtask

  // all sources high: every reserved bit still reads zero
  task automatic t_ones;
    logic [31:0] d;
    w = '{default: '1};
    for (int i = 0; i < 6; i++)
    begin
      rd(OFS[i], d);
      chk("reserved bits", d, expw(i, '1));
    end
  endtask

  // write attempt together with read strobe: no answer at all
  task automatic t_refused;
    wr = 1;
    addr = MFSB_OFS_CTRL;
    go = 1;
    @(posedge clk_sys) #1 go = 0;
    wr = 0;
    repeat (3)
      @(posedge clk_sys) #1 chk("refused", rd_valid, 0);
  endtask

  // back-to-back reads: unchanged mapped word, then an unmapped offset
  task automatic t_pair;
    addr = MFSB_OFS_CTRL;
    go = 1;
    @(posedge clk_sys) #1 addr = 12'h0e1;
    @(posedge clk_sys) #1 go = 0;
    chk("first valid", rd_valid, 1);
    chk("first of pair", rd_data, expw(1, '1));
    @(posedge clk_sys) #1 chk("unmapped valid", rd_valid, 1);
    chk("unmapped data", rd_data, 0);
  endtask

  // reset in mid-run with sources active: outputs clear, then recover
  task automatic t_reset;
    logic [31:0] d;
    rst_b = 0;
    @(posedge clk_sys) #1 chk("reset valid", rd_valid, 0);
    chk("reset data", rd_data, 0);
    chk("reset drv sum", driver_fault_any, 0);
    chk("reset ctl sum", controller_fault_any, 0);
    @(posedge clk_sys) #1 rst_b = 1;
    repeat (3) @(posedge clk_sys);
    #1 rd(MFSB_OFS_CTRL, d);
    chk("after reset", d, expw(1, '1));
    chk("drv sum after", driver_fault_any, 1);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1 rst_b = 1;
    repeat (3) @(posedge clk_sys);
    #1 t_walk();
    t_ones();
    t_refused();
    t_pair();
    t_reset();
    give_verdict();
  end
endmodule
